//--- dv/mgmt_host_model.sv
// Host controller model for the two-wire management bus
`timescale 1ns/10ps
module mgmt_host_model (
	input  wire logic clk_sys,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_low
);
	// Idle bus: clock stands high, data released to the pull-up
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Half of the 200 ns bus period
	task automatic half_bit();
		repeat (4) @(negedge clk_sys);
	endtask : half_bit

	// Start or repeated start: data falls while clock high
	task automatic bus_start();
		sda_low = 1'b0;
		half_bit();
		scl = 1'b1;
		half_bit();
		sda_low = 1'b1;
		half_bit();
		scl = 1'b0;
	endtask : bus_start

	// Stop: data rises while clock high, then the line is released
	task automatic bus_stop();
		sda_low = 1'b1;
		half_bit();
		scl = 1'b1;
		half_bit();
		sda_low = 1'b0;
		half_bit();
	endtask : bus_stop

	// Data only moves while clock is low; sampled at the end of the high phase
	task automatic bit_io(input logic b, output logic s);
		sda_low = !b;
		half_bit();
		scl = 1'b1;
		half_bit();
		s = sda_line;
		scl = 0;
	endtask : bit_io

	// Eight bits msb first, then the acknowledge slot
	task automatic byte_io(input logic [7:0] d, input logic ack_drv, output logic [7:0] q,
		output logic ack_seen);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(ack_drv, s);
		ack_seen = !s;
	endtask : byte_io
endmodule : mgmt_host_model

//--- dv/mgmt_status_sva.sv
// Port-level assertions for the management sideband block
`timescale 1ns/10ps
module mgmt_status_sva #(
	parameter int INIT_CYCLES = 200,
	parameter int WAKE_CYCLES = 100
) (
	input wire logic                        clk_sys,
	input wire logic                        rst,
	input wire logic                        scl_in,
	input wire logic                        sda_in,
	input wire logic                        sda_out,
	input wire logic                        sda_oe,
	input wire logic                        module_select_n,
	input wire logic                        module_restart_n,
	input wire logic                        low_power_request,
	input wire logic [mgmt_pkg::COND_W-1:0] fault_cond,
	input wire logic                        attention_n,
	input wire logic                        attention_oe,
	input wire logic                        low_power,
	input wire logic                        presence_n
);
	logic [6:0] restart_low_r;

	default clocking main_cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////////
	// Restart low time, saturating so a long hold never wraps
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			restart_low_r <= 7'h00;
		end else if (module_restart_n) begin
			restart_low_r <= 7'h00;
		end else if (restart_low_r != 7'h7f) begin
			restart_low_r <= restart_low_r + 7'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin relations
	oe_pair_a: assert property (attention_oe == !attention_n)
		else $error("attention enable disagrees with attention level");
	od_data_a: assert property (sda_oe |-> !sda_out)
		else $error("data line driven high");
	lp_rise_a: assert property ($rose(low_power_request) |-> ##[1:6] low_power)
		else $error("low power late after request");
	lp_level_a: assert property (low_power_request [*6] |-> low_power)
		else $error("low power dropped under request");
	desel_quiet_a: assert property (module_select_n [*5] |-> !sda_oe)
		else $error("bus answered while deselected");
	restart_lp_a: assert property (restart_low_r >= 7'h5f |-> low_power)
		else $error("held restart not in low power");
	restart_bus_a: assert property (restart_low_r >= 7'h5f |-> !sda_oe)
		else $error("held restart still answering bus");
	edge_change_a: assert property ($changed(sda_oe) && !module_select_n && module_restart_n
		|-> !scl_in)
		else $error("data changed while bus clock high");
endmodule : mgmt_status_sva

bind module_mgmt_status_control mgmt_status_sva #(
	.INIT_CYCLES(INIT_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)
) sva_i (
	.clk_sys(clk_sys), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .module_select_n(module_select_n), .module_restart_n(module_restart_n),
	.low_power_request(low_power_request), .fault_cond(fault_cond),
	.attention_n(attention_n), .attention_oe(attention_oe), .low_power(low_power),
	.presence_n(presence_n)
);

//--- dv/tb_top.sv
// Self-checking bench for the management sideband block
`timescale 1ns/10ps
module tb_top;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic       sda_line;
	logic       sda_out;
	logic       sda_oe;
	logic       host_scl;
	logic       host_sda_low;
	logic       module_select_n = 1'b0;
	logic       module_restart_n = 1'b1;
	logic       low_power_request = 1'b0;
	logic [6:0] fault_cond = 7'h00;
	logic       attention_n;
	logic       attention_oe;
	logic       low_power;
	logic       presence_n;
	int         n_errors = 0;
	int         checked = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Clock, open-drain data line with pull-up, instances
	always #12.5 clk_sys = !clk_sys;
	assign sda_line = !(sda_oe | host_sda_low);

	module_mgmt_status_control #(.INIT_CYCLES(200), .WAKE_CYCLES(100)) dut (
		.clk_sys(clk_sys), .rst(rst), .scl_in(host_scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .module_select_n(module_select_n),
		.module_restart_n(module_restart_n), .low_power_request(low_power_request),
		.fault_cond(fault_cond), .attention_n(attention_n), .attention_oe(attention_oe),
		.low_power(low_power), .presence_n(presence_n));
	mgmt_host_model host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(host_scl),
		.sda_low(host_sda_low));

	////////////////////////////////////////////////////////////////////////////////
	// Shared checks and bus cycles
	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("Error %0t %s", $time, m);
		end
	endtask : chk

	// Bounded wait for a level, then judged
	task automatic wait_on(ref logic s, input logic v, input int lim, input string m);
		int i;
		i = 0;
		while (s !== v && i < lim) begin
			@(negedge clk_sys);
			i++;
		end
		chk(s === v, m);
	endtask : wait_on

	task automatic xfer(input logic [7:0] ofs, input logic rd, input logic [7:0] d,
		output logic ok, output logic [7:0] q);
		logic a0, a1, a2, n;
		logic [7:0] x;
		host.bus_start();
		host.byte_io({mgmt_pkg::DEV_ADDR, 1'b0}, 1'b1, x, a0);
		host.byte_io(ofs, 1'b1, x, a1);
		if (rd) begin
			host.bus_start();
			host.byte_io({mgmt_pkg::DEV_ADDR, 1'b1}, 1'b1, x, a2);
			host.byte_io(8'hff, 1'b1, q, n);
		end else begin
			host.byte_io(d, 1'b1, x, a2);
		end
		host.bus_stop();
		ok = a0 & a1 & a2;
	endtask : xfer

	task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
		logic ok;
		logic [7:0] q;
		xfer(ofs, 1'b1, 8'h00, ok, q);
		chk(ok === 1'b1 && q === exp, "read mismatch");
	endtask : rd_chk

	task automatic wr(input logic [7:0] ofs, input logic [7:0] d, input logic exp_ok);
		logic ok;
		logic [7:0] q;
		xfer(ofs, 1'b0, d, ok, q);
		chk(ok === exp_ok, "write acknowledge");
	endtask : wr

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_init();
		wait_on(attention_n, 1'b0, 260, "no ready attention");
		chk(presence_n === 1'b0 && attention_oe === 1'b1, "presence or attention enable");
		rd_chk(mgmt_pkg::OFS_STATUS, 8'h00);
		rd_chk(mgmt_pkg::OFS_FLAG, 8'h80);
		wait_on(attention_n, 1'b1, 20, "attention stuck after read");
	endtask : t_init

	// Each condition latches its own flag, even once gone
	task automatic t_flags();
		for (int i = 0; i < 7; i++) begin
			fault_cond = 7'h01 << i;
			wait_on(attention_n, 1'b0, 8, "condition attention");
			fault_cond = 7'h00;
			rd_chk(mgmt_pkg::OFS_FLAG, 8'h01 << i);
			wait_on(attention_n, 1'b1, 20, "flag release");
		end
		rd_chk(mgmt_pkg::OFS_FLAG, 8'h00);
	endtask : t_flags

	task automatic t_mask();
		wr(mgmt_pkg::OFS_MASK, 8'h01, 1'b1);
		fault_cond = 7'h01;
		repeat (20) @(negedge clk_sys);
		chk(attention_n === 1'b1, "masked flag raised attention");
		wr(mgmt_pkg::OFS_MASK, 8'h00, 1'b1);
		wait_on(attention_n, 1'b0, 20, "unmask no attention");
		fault_cond = 7'h00;
		rd_chk(mgmt_pkg::OFS_FLAG, 8'h01);
		wait_on(attention_n, 1'b1, 20, "release after unmask");
	endtask : t_mask

	task automatic t_power();
		low_power_request = 1'b1;
		wait_on(low_power, 1'b1, 8, "request low power");
		low_power_request = 1'b0;
		wait_on(low_power, 1'b0, 8, "leave low power");
		wr(mgmt_pkg::OFS_CTRL, 8'h01, 1'b1);
		wait_on(low_power, 1'b1, 8, "power-down bit");
		wr(mgmt_pkg::OFS_CTRL, 8'h00, 1'b1);
		wait_on(attention_n, 1'b0, 130, "wake not signalled");
		chk(low_power === 1'b0, "still low power");
		rd_chk(mgmt_pkg::OFS_FLAG, 8'h80);
		wait_on(attention_n, 1'b1, 20, "wake release");
	endtask : t_power

	// Deselected and wrongly addressed requests go unanswered
	task automatic t_select();
		logic a;
		logic [7:0] x;
		module_select_n = 1'b1;
		// Host keeps off the bus for the whole 100 us release window
		repeat (4000) @(negedge clk_sys);
		wr(mgmt_pkg::OFS_MASK, 8'h00, 1'b0);
		module_select_n = 1'b0;
		repeat (8) @(negedge clk_sys);
		wr(mgmt_pkg::OFS_MASK, 8'h00, 1'b1);
		host.bus_start();
		host.byte_io(8'ha2, 1'b1, x, a);
		host.bus_stop();
		chk(a === 1'b0, "foreign address acknowledged");
	endtask : t_select

	task automatic t_restart();
		module_restart_n = 1'b0;
		repeat (40) @(negedge clk_sys);
		module_restart_n = 1'b1;
		repeat (8) @(negedge clk_sys);
		chk(low_power === 1'b0, "short restart pulse taken");
		module_restart_n = 1'b0;
		repeat (100) @(negedge clk_sys);
		chk(low_power === 1'b1, "held restart not taken");
		wr(mgmt_pkg::OFS_MASK, 8'h00, 1'b0);
		module_restart_n = 1'b1;
		wait_on(attention_n, 1'b0, 260, "restart not ready");
		rd_chk(mgmt_pkg::OFS_FLAG, 8'h80);
	endtask : t_restart

	////////////////////////////////////////////////////////////////////////////////
	// Verdict, main sequence and watchdog
	task automatic final_report();
		$display("checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		t_init();
		t_flags();
		t_mask();
		t_power();
		t_select();
		t_restart();
		final_report();
	end

	// Whole run needs well under half a millisecond
	initial begin
		#2000000;
		n_errors++;
		$display("Error %0t watchdog expired", $time);
		final_report();
	end
endmodule : tb_top

//--- rtl/hold_timer.sv
// Down-counting delay that pulses done once its load has elapsed
`timescale 1ns/10ps
module hold_timer #(
	parameter int W = 27
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	input  wire logic         hold,
	output logic              done
);
	logic [W-1:0] cnt_r;
	logic         run_r;

	// Hold keeps the count parked at its load value
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			run_r <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load || hold) begin
				cnt_r <= count;
				run_r <= 1'b1;
			end else if (run_r) begin
				if (cnt_r <= W'(1)) begin
					run_r <= 1'b0;
					done  <= 1'b1;
				end else begin
					cnt_r <= cnt_r - W'(1);
				end
			end
		end
	end
endmodule : hold_timer

//--- rtl/mgmt_pkg.sv
// Constants, states and carriers for the module management sideband
package mgmt_pkg;
	localparam int CLK_NS = 25;
	// Minimum restart pulse and the timed responses
	localparam int RESTART_MIN_NS = 2000;
	localparam int RESTART_MIN_CYC = (RESTART_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int INIT_TIME_MS = 2000;
	localparam int INIT_CYC = INIT_TIME_MS * (1000000 / CLK_NS);
	localparam int WAKE_TIME_MS = 300;
	localparam int WAKE_CYC = WAKE_TIME_MS * (1000000 / CLK_NS);
	localparam int TMR_W = 27;
	// Management bus address and byte map
	localparam logic [6:0] DEV_ADDR = 7'h50;
	localparam logic [7:0] OFS_STATUS = 8'h02;
	localparam logic [7:0] OFS_FLAG = 8'h03;
	localparam logic [7:0] OFS_MASK = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h05;
	localparam int STATUS_DNR_BIT = 0;
	localparam int STATUS_LP_BIT = 1;
	localparam int CTRL_PDOWN_BIT = 0;
	localparam int FLAG_READY_BIT = 7;
	localparam int COND_W = 7;
	// Reset values, and the bit count that ends a byte
	localparam logic [7:0] FLAG_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [3:0] BIT_LAST = 4'h8;

	typedef enum logic [6:0] {
		BUS_IDLE = 7'b000_0001,
		BUS_ADDR = 7'b000_0010,
		BUS_AACK = 7'b000_0100,
		BUS_WR   = 7'b000_1000,
		BUS_WACK = 7'b001_0000,
		BUS_RD   = 7'b010_0000,
		BUS_RACK = 7'b100_0000
	} bus_state_e;

	typedef enum logic [2:0] {
		PW_INIT = 3'b001,
		PW_RUN  = 3'b010,
		PW_HOLD = 3'b100
	} pw_state_e;

	// Pins from outside the clock domain, synchronised as one group
	typedef struct packed {
		logic                scl;
		logic                sda;
		logic                select_n;
		logic                restart_n;
		logic                lp_req;
		logic [COND_W-1:0]   cond;
	} pins_s;

	// Idle level of each pin, loaded into the synchroniser at reset
	localparam pins_s PIN_IDLE = '{scl: 1'b1, sda: 1'b1, select_n: 1'b1, restart_n: 1'b1,
		lp_req: 1'b0, cond: '0};
endpackage : mgmt_pkg

//--- rtl/module_mgmt_status_control.sv
// Management bus slave, latched flags, attention and power control
`timescale 1ns/10ps
module module_mgmt_status_control #(
	parameter int INIT_CYCLES = mgmt_pkg::INIT_CYC,
	parameter int WAKE_CYCLES = mgmt_pkg::WAKE_CYC
) (
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	input  wire logic                        scl_in,
	input  wire logic                        sda_in,
	output logic                             sda_out,
	output logic                             sda_oe,
	input  wire logic                        module_select_n,
	input  wire logic                        module_restart_n,
	input  wire logic                        low_power_request,
	input  wire logic [mgmt_pkg::COND_W-1:0] fault_cond,
	output logic                             attention_n,
	output logic                             attention_oe,
	output logic                             low_power,
	output logic                             presence_n
);
	mgmt_pkg::pins_s       pin_raw;
	mgmt_pkg::pins_s       pin_s;
	mgmt_pkg::bus_state_e  bus_r;
	mgmt_pkg::pw_state_e   pw_r;
	logic                  scl_q;
	logic                  sda_q;
	logic                  scl_rise;
	logic                  scl_fall;
	logic                  bus_start;
	logic                  bus_stop;
	logic                  bus_en;
	logic [3:0]            bit_r;
	logic [7:0]            sh_r;
	logic [7:0]            ptr_r;
	logic                  rw_r;
	logic                  first_r;
	logic [7:0]            flag_r;
	logic [7:0]            flag_set;
	logic [7:0]            rd_clr_r;
	logic [7:0]            clr_now;
	logic [7:0]            mask_r;
	logic [7:0]            ctrl_r;
	logic                  dnr_r;
	logic                  ready_evt;
	logic                  pdown_q;
	logic                  wake_evt;
	logic [7:0]            rd_byte;
	logic [7:0]            status_byte;
	logic [7:0]            restart_cnt_r;
	logic                  restart_hold_r;
	logic                  restart_q;
	logic                  restart_rise;
	logic                  tmr_load;
	logic [mgmt_pkg::TMR_W-1:0] tmr_count;
	logic                  boot_r;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation; all pins idle high except the low-power request and the conditions
	assign pin_raw = '{scl: scl_in, sda: sda_in, select_n: module_select_n,
		restart_n: module_restart_n, lp_req: low_power_request, cond: fault_cond};

	pin_sync #(
		.W($bits(mgmt_pkg::pins_s)),
		.RST_VAL(mgmt_pkg::PIN_IDLE)
	) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.d       (pin_raw),
		.q       (pin_s)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus line edges, start and stop detection
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= pin_s.scl;
			sda_q <= pin_s.sda;
		end
	end

	assign scl_rise  = pin_s.scl & ~scl_q;
	assign scl_fall  = ~pin_s.scl & scl_q;
	assign bus_start = pin_s.scl & scl_q & sda_q & ~pin_s.sda;
	assign bus_stop  = pin_s.scl & scl_q & ~sda_q & pin_s.sda;
	// Answer only while selected and not held in restart
	assign bus_en    = ~pin_s.select_n & ~restart_hold_r;

	////////////////////////////////////////////////////////////////////////
	// Byte map seen by reads
	always_comb begin
		status_byte = 8'h00;
		status_byte[mgmt_pkg::STATUS_DNR_BIT] = dnr_r;
		status_byte[mgmt_pkg::STATUS_LP_BIT]  = low_power;
		case (ptr_r)
			mgmt_pkg::OFS_STATUS: rd_byte = status_byte;
			mgmt_pkg::OFS_FLAG:   rd_byte = flag_r;
			mgmt_pkg::OFS_MASK:   rd_byte = mask_r;
			mgmt_pkg::OFS_CTRL:   rd_byte = ctrl_r;
			default:              rd_byte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Bus slave: bits sampled on clock rise, driven after clock fall
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bus_r    <= mgmt_pkg::BUS_IDLE;
			bit_r    <= 4'h0;
			sh_r     <= 8'h00;
			ptr_r    <= 8'h00;
			rw_r     <= 1'b0;
			first_r  <= 1'b0;
			sda_oe   <= 1'b0;
			mask_r   <= mgmt_pkg::MASK_RST;
			ctrl_r   <= mgmt_pkg::CTRL_RST;
			rd_clr_r <= 8'h00;
		end else if (!bus_en || bus_stop) begin
			// Deselect aborts mid-transfer and frees the data line
			bus_r    <= mgmt_pkg::BUS_IDLE;
			sda_oe   <= 1'b0;
			rd_clr_r <= 8'h00;
		end else if (bus_start) begin
			bus_r  <= mgmt_pkg::BUS_ADDR;
			bit_r  <= 4'h0;
			sda_oe <= 1'b0;
		end else begin
			case (bus_r)
				mgmt_pkg::BUS_ADDR, mgmt_pkg::BUS_WR: begin
					if (scl_rise) begin
						sh_r  <= {sh_r[6:0], pin_s.sda};
						bit_r <= bit_r + 4'h1;
					end else if (scl_fall && bit_r == mgmt_pkg::BIT_LAST) begin
						if (bus_r == mgmt_pkg::BUS_ADDR) begin
							// Foreign address: stay off the line
							if (sh_r[7:1] == mgmt_pkg::DEV_ADDR) begin
								bus_r  <= mgmt_pkg::BUS_AACK;
								rw_r   <= sh_r[0];
								sda_oe <= 1'b1;
							end else begin
								bus_r <= mgmt_pkg::BUS_IDLE;
							end
						end else begin
							if (first_r) begin
								ptr_r <= sh_r;
							end else begin
								// Takes effect at once, well inside the window
								if (ptr_r == mgmt_pkg::OFS_MASK) begin
									mask_r <= sh_r;
								end
								if (ptr_r == mgmt_pkg::OFS_CTRL) begin
									ctrl_r <= sh_r;
								end
								ptr_r <= ptr_r + 8'h01;
							end
							first_r <= 1'b0;
							bus_r   <= mgmt_pkg::BUS_WACK;
							sda_oe  <= 1'b1;
						end
					end
				end
				mgmt_pkg::BUS_AACK, mgmt_pkg::BUS_WACK: begin
					if (scl_fall) begin
						bit_r <= 4'h0;
						if (bus_r == mgmt_pkg::BUS_AACK && rw_r) begin
							bus_r  <= mgmt_pkg::BUS_RD;
							sh_r   <= rd_byte;
							sda_oe <= ~rd_byte[7];
							if (ptr_r == mgmt_pkg::OFS_FLAG) begin
								rd_clr_r <= rd_clr_r | flag_r;
							end
						end else begin
							if (bus_r == mgmt_pkg::BUS_AACK) begin
								first_r <= 1'b1;
							end
							bus_r  <= mgmt_pkg::BUS_WR;
							sda_oe <= 1'b0;
						end
					end
				end
				mgmt_pkg::BUS_RD: begin
					if (scl_rise) begin
						bit_r <= bit_r + 4'h1;
					end else if (scl_fall) begin
						if (bit_r == mgmt_pkg::BIT_LAST) begin
							bus_r  <= mgmt_pkg::BUS_RACK;
							sda_oe <= 1'b0;
							ptr_r  <= ptr_r + 8'h01;
						end else begin
							sh_r   <= {sh_r[6:0], 1'b0};
							sda_oe <= ~sh_r[6];
						end
					end
				end
				mgmt_pkg::BUS_RACK: begin
					// Host NACK ends the read; wait for stop
					if (scl_rise) begin
						rw_r <= ~pin_s.sda;
					end else if (scl_fall) begin
						if (rw_r) begin
							bus_r  <= mgmt_pkg::BUS_RD;
							bit_r  <= 4'h0;
							sh_r   <= rd_byte;
							sda_oe <= ~rd_byte[7];
							if (ptr_r == mgmt_pkg::OFS_FLAG) begin
								rd_clr_r <= rd_clr_r | flag_r;
							end
						end else begin
							bus_r <= mgmt_pkg::BUS_IDLE;
						end
					end
				end
				default: begin
					// Idle and any stray code keep the line free
					bus_r  <= mgmt_pkg::BUS_IDLE;
					sda_oe <= 1'b0;
				end
			endcase
		end
	end

	// Read flags are cleared when the read's stop is seen, ahead of the window
	assign clr_now = bus_stop ? rd_clr_r : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Latched flags; a new condition beats a clear in the same cycle
	always_comb begin
		flag_set = {1'b0, pin_s.cond};
		flag_set[mgmt_pkg::FLAG_READY_BIT] = ready_evt;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_r <= mgmt_pkg::FLAG_RST;
		end else begin
			flag_r <= (flag_r & ~clr_now) | flag_set;
		end
	end

	// Attention low while any unmasked flag stands; one cycle behind the flag
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			attention_n  <= 1'b1;
			attention_oe <= 1'b0;
		end else begin
			attention_n  <= ~|(flag_r & ~mask_r);
			attention_oe <= |(flag_r & ~mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Restart pin qualified by minimum low time
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			restart_cnt_r  <= 8'h00;
			restart_hold_r <= 1'b0;
			restart_q      <= 1'b1;
		end else begin
			restart_q <= pin_s.restart_n;
			if (pin_s.restart_n) begin
				restart_cnt_r  <= 8'h00;
				restart_hold_r <= 1'b0;
			end else if (restart_cnt_r > 8'(mgmt_pkg::RESTART_MIN_CYC)) begin
				restart_hold_r <= 1'b1;
			end else begin
				restart_cnt_r <= restart_cnt_r + 8'h01;
			end
		end
	end

	assign restart_rise = pin_s.restart_n & ~restart_q & restart_hold_r;

	////////////////////////////////////////////////////////////////////////
	// Initialisation and power level control
	assign wake_evt  = pdown_q & ~ctrl_r[mgmt_pkg::CTRL_PDOWN_BIT];
	assign tmr_load  = restart_rise | wake_evt | boot_r;
	assign tmr_count = wake_evt ? mgmt_pkg::TMR_W'(WAKE_CYCLES)
		: mgmt_pkg::TMR_W'(INIT_CYCLES);

	hold_timer #(
		.W(mgmt_pkg::TMR_W)
	) u_init_tmr (
		.clk_sys (clk_sys),
		.rst     (rst),
		.load    (tmr_load),
		.count   (tmr_count),
		.hold    (restart_hold_r & ~restart_rise),
		.done    (ready_evt)
	);

	// One-shot boot load starts the timer, so power-on init is covered as well
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pw_r    <= mgmt_pkg::PW_INIT;
			dnr_r   <= 1'b1;
			pdown_q <= 1'b0;
			boot_r  <= 1'b1;
		end else begin
			boot_r  <= 1'b0;
			pdown_q <= ctrl_r[mgmt_pkg::CTRL_PDOWN_BIT];
			case (pw_r)
				mgmt_pkg::PW_INIT: begin
					if (restart_hold_r) begin
						pw_r <= mgmt_pkg::PW_HOLD;
					end else if (ready_evt) begin
						pw_r  <= mgmt_pkg::PW_RUN;
						dnr_r <= 1'b0;
					end
				end
				mgmt_pkg::PW_RUN: begin
					if (restart_hold_r || wake_evt) begin
						pw_r  <= restart_hold_r ? mgmt_pkg::PW_HOLD : mgmt_pkg::PW_INIT;
						dnr_r <= 1'b1;
					end
				end
				mgmt_pkg::PW_HOLD: begin
					dnr_r <= 1'b1;
					if (restart_rise) begin
						pw_r <= mgmt_pkg::PW_INIT;
					end
				end
				default: begin
					pw_r <= mgmt_pkg::PW_INIT;
				end
			endcase
		end
	end

	// Lower power follows the pin, the control bit and the restart hold state
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			low_power  <= 1'b1;
			presence_n <= 1'b0;
			sda_out    <= 1'b0;
		end else begin
			low_power  <= pin_s.lp_req | ctrl_r[mgmt_pkg::CTRL_PDOWN_BIT]
				| (pw_r == mgmt_pkg::PW_HOLD);
			presence_n <= 1'b0;
			sda_out    <= 1'b0;
		end
	end
endmodule : module_mgmt_status_control

//--- rtl/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
module pin_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// One pair of flops per bit; first stage feeds only the second
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk_sys or posedge rst) begin
			// Idle level at reset, so no false edge or flag follows release
			if (rst) begin
				meta_r[i] <= RST_VAL[i];
				q[i]      <= RST_VAL[i];
			end else begin
				meta_r[i] <= d[i];
				q[i]      <= meta_r[i];
			end
		end
	end
endmodule : pin_sync
